// ---- design/fpc_flash_regs.vh ----
// Constants for the parallel flash command and status controller
`ifndef FPC_FLASH_REGS_VH
`define FPC_FLASH_REGS_VH

// Host command opcodes
`define FPC_OP_READ      3'h0
`define FPC_OP_PROGRAM   3'h1
`define FPC_OP_CHIP_ERS  3'h2
`define FPC_OP_SECT_ERS  3'h3
`define FPC_OP_ID_ENTRY  3'h4
`define FPC_OP_ID_EXIT   3'h5
`define FPC_OP_ID_EXIT2  3'h6
`define FPC_OP_LOCKOUT   3'h7

// Command addresses and data bytes
`define FPC_CMD_ADDR1    15'h5555
`define FPC_CMD_ADDR2    15'h2aaa
`define FPC_DAT_UNLOCK1  8'haa
`define FPC_DAT_UNLOCK2  8'h55
`define FPC_DAT_ERS_SET  8'h80
`define FPC_DAT_PROGRAM  8'ha0
`define FPC_DAT_CHIP_ERS 8'h10
`define FPC_DAT_SECT_ERS 8'h30
`define FPC_DAT_ID_ENTRY 8'h90
`define FPC_DAT_ID_EXIT  8'hf0
`define FPC_DAT_LOCKOUT  8'h40

// Boot block word range
`define FPC_BOOT_LO      18'h0_0000
`define FPC_BOOT_HI      18'h0_1fff

// Toggle status data line position
`define FPC_TOGGLE_BIT   6

// Clock and pin timing
`define FPC_CLK_NS       40
`define FPC_T_AS_NS      10
`define FPC_T_WP_NS      90
`define FPC_T_WPH_NS     90
`define FPC_T_DH_NS      10
`define FPC_T_ACC_NS     120
`define FPC_T_POLL_HIGH_NS 150
`define FPC_T_BP_US      50
`define FPC_T_EC_S       10

// Cycle counts at the 40 ns clock, rounded up
`define FPC_AS_CYC        3'h1
`define FPC_WP_CYC        3'h3
`define FPC_WPH_CYC       3'h3
`define FPC_DH_CYC        3'h1
`define FPC_ACC_CYC       3'h3
`define FPC_POLL_HIGH_CYC 3'h4
`define FPC_BP_CYC        28'h000_04e2
`define FPC_EC_CYC        28'hee6_b280

`endif

// ---- design/fpc_seq_rom.v ----
// Command sequence table with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "fpc_flash_regs.vh"

module fpc_seq_rom (
  input  wire        i_clk,
  input  wire        i_reset_n,
  input  wire [2:0]  i_op,
  input  wire [2:0]  i_step,
  output reg  [14:0] o_addr,
  output reg  [7:0]  o_data,
  output reg         o_uaddr,
  output reg         o_udata,
  output reg         o_last
);

  reg [14:0] addr_next;
  reg [7:0]  data_next;
  reg        uaddr_next;
  reg        udata_next;
  reg        last_next;

  always @* begin
    addr_next  = `FPC_CMD_ADDR1;
    data_next  = `FPC_DAT_UNLOCK1;
    uaddr_next = 1'b0;
    udata_next = 1'b0;
    last_next  = 1'b0;
    if (i_step == 3'h1 || i_step == 3'h4) begin
      addr_next = `FPC_CMD_ADDR2;
      data_next = `FPC_DAT_UNLOCK2;
    end
    case (i_op)
      `FPC_OP_PROGRAM: begin
        if (i_step == 3'h2) data_next = `FPC_DAT_PROGRAM;
        if (i_step == 3'h3) begin
          uaddr_next = 1'b1;
          udata_next = 1'b1;
          last_next  = 1'b1;
        end
      end
      `FPC_OP_CHIP_ERS, `FPC_OP_SECT_ERS, `FPC_OP_LOCKOUT: begin
        if (i_step == 3'h2) data_next = `FPC_DAT_ERS_SET;
        if (i_step == 3'h5) begin
          last_next = 1'b1;
          if (i_op == `FPC_OP_CHIP_ERS) begin
            data_next = `FPC_DAT_CHIP_ERS;
          end else if (i_op == `FPC_OP_SECT_ERS) begin
            data_next  = `FPC_DAT_SECT_ERS;
            uaddr_next = 1'b1;
          end else begin
            data_next = `FPC_DAT_LOCKOUT;
          end
        end
      end
      `FPC_OP_ID_ENTRY: begin
        if (i_step == 3'h2) begin
          data_next = `FPC_DAT_ID_ENTRY;
          last_next = 1'b1;
        end
      end
      `FPC_OP_ID_EXIT: begin
        if (i_step == 3'h2) begin
          data_next = `FPC_DAT_ID_EXIT;
          last_next = 1'b1;
        end
      end
      `FPC_OP_ID_EXIT2: begin
        data_next = `FPC_DAT_ID_EXIT;
        last_next = 1'b1;
      end
      default: begin
        last_next = 1'b1;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_addr  <= 15'h0000;
      o_data  <= 8'h00;
      o_uaddr <= 1'b0;
      o_udata <= 1'b0;
      o_last  <= 1'b0;
    end else begin
      o_addr  <= addr_next;
      o_data  <= data_next;
      o_uaddr <= uaddr_next;
      o_udata <= udata_next;
      o_last  <= last_next;
    end
  end

endmodule // fpc_seq_rom

`default_nettype wire

// ---- design/fpc_flash_host.v ----
// Host controller driving a 16-bit parallel flash through its strobes
// Functional notes
// - The chip-erase sequence ends with a write to command address 5555.
// - The final erase write carries 10 hex for chip erase and 30 hex for sector erase.
// - Sector erase puts the user address of the target sector on the final write.
// - Output enable stays high while write strobe and chip select are low.
// - All polling reads of one operation use the same address.
// - Command cycles put data in the low byte and use only the low fifteen address bits, except the program data write and the final sector-erase write.
`timescale 1ns/100ps
`default_nettype none
`include "fpc_flash_regs.vh"

module fpc_flash_host #(
  parameter [27:0] P_ERASE_TMO_CYC = `FPC_EC_CYC
) (
  input  wire        i_clk,
  input  wire        i_reset_n,
  input  wire        i_cmd_valid,
  input  wire [2:0]  i_cmd_op,
  input  wire [17:0] i_cmd_addr,
  input  wire [15:0] i_cmd_wdata,
  output reg         o_cmd_ready,
  output reg         o_done,
  output reg         o_error,
  output reg         o_refused,
  output reg  [15:0] o_rdata,
  output reg         o_id_mode,
  output reg         o_lockout_active,
  output reg  [17:0] o_flash_addr,
  output reg         o_flash_ce_n,
  output reg         o_flash_oe_n,
  output reg         o_flash_we_n,
  output reg  [15:0] o_flash_dq_out,
  output reg         o_flash_dq_oe,
  input  wire [15:0] i_flash_dq_in
);

  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_FETCH = 4'h1;
  localparam [3:0] S_WSET  = 4'h2;
  localparam [3:0] S_WLOW  = 4'h3;
  localparam [3:0] S_WHOLD = 4'h4;
  localparam [3:0] S_WGAP  = 4'h5;
  localparam [3:0] S_PGAP  = 4'h6;
  localparam [3:0] S_PRD   = 4'h7;
  localparam [3:0] S_RD    = 4'h8;
  localparam [3:0] S_RGAP  = 4'h9;

  localparam [2:0]  L_AS    = `FPC_AS_CYC;
  localparam [2:0]  L_WP    = `FPC_WP_CYC - 3'h1;
  localparam [2:0]  L_WPH   = `FPC_WPH_CYC - 3'h1;
  localparam [2:0]  L_DH    = `FPC_DH_CYC - 3'h1;
  localparam [2:0]  L_ACC   = `FPC_ACC_CYC - 3'h1;
  localparam [2:0]  L_POLL_HIGH = `FPC_POLL_HIGH_CYC - 3'h1;
  localparam [27:0] L_PROG_TMO = `FPC_BP_CYC;

  // Program target inside the boot block
  function in_boot;
    input [17:0] addr;
    begin
      in_boot = (addr <= `FPC_BOOT_HI);
    end
  endfunction

  reg [3:0]  state_reg;
  reg [2:0]  cnt_reg;
  reg [2:0]  op_reg;
  reg [2:0]  step_reg;
  reg [17:0] uaddr_reg;
  reg [15:0] udata_reg;
  reg        prev_tog_reg;
  reg        have_prev_reg;
  reg [27:0] tmo_reg;

  wire [14:0] rom_addr;
  wire [7:0]  rom_data;
  wire        rom_uaddr;
  wire        rom_udata;
  wire        rom_last;
  wire        is_erase;
  wire        tog_now;
  wire [27:0] tmo_limit;

  assign is_erase  = (op_reg == `FPC_OP_CHIP_ERS) || (op_reg == `FPC_OP_SECT_ERS);
  assign tog_now   = i_flash_dq_in[`FPC_TOGGLE_BIT];
  assign tmo_limit = is_erase ? P_ERASE_TMO_CYC : L_PROG_TMO;

  fpc_seq_rom u_rom (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_op      (op_reg),
    .i_step    (step_reg),
    .o_addr    (rom_addr),
    .o_data    (rom_data),
    .o_uaddr   (rom_uaddr),
    .o_udata   (rom_udata),
    .o_last    (rom_last)
  );

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg        <= S_IDLE;
      cnt_reg          <= 3'h0;
      op_reg           <= `FPC_OP_READ;
      step_reg         <= 3'h0;
      uaddr_reg        <= 18'h0_0000;
      udata_reg        <= 16'h0000;
      prev_tog_reg     <= 1'b0;
      have_prev_reg    <= 1'b0;
      tmo_reg          <= 28'h000_0000;
      o_cmd_ready      <= 1'b0;
      o_done           <= 1'b0;
      o_error          <= 1'b0;
      o_refused        <= 1'b0;
      o_rdata          <= 16'h0000;
      o_id_mode        <= 1'b0;
      o_lockout_active <= 1'b0;
      o_flash_addr     <= 18'h0_0000;
      o_flash_ce_n     <= 1'b1;
      o_flash_oe_n     <= 1'b1;
      o_flash_we_n     <= 1'b1;
      o_flash_dq_out   <= 16'h0000;
      o_flash_dq_oe    <= 1'b0;
    end else begin
      o_done    <= 1'b0;
      o_refused <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          o_cmd_ready <= 1'b1;
          if (i_cmd_valid && o_cmd_ready) begin
            o_cmd_ready <= 1'b0;
            o_error     <= 1'b0;
            op_reg      <= i_cmd_op;
            uaddr_reg   <= i_cmd_addr;
            udata_reg   <= i_cmd_wdata;
            step_reg    <= 3'h0;
            cnt_reg     <= 3'h0;
            if (i_cmd_op == `FPC_OP_READ) begin
              // Identification reads take the same path; address bit 0 picks the code
              o_flash_addr <= i_cmd_addr;
              o_flash_ce_n <= 1'b0;
              o_flash_oe_n <= 1'b0;
              state_reg    <= S_RD;
            end else if (i_cmd_op == `FPC_OP_PROGRAM && o_lockout_active &&
                         in_boot(i_cmd_addr)) begin
              o_refused   <= 1'b1;
              o_done      <= 1'b1;
              o_cmd_ready <= 1'b1;
            end else begin
              state_reg <= S_FETCH;
            end
          end
        end
        S_FETCH: begin
          state_reg <= S_WSET;
        end
        S_WSET: begin
          o_flash_addr   <= rom_uaddr ? uaddr_reg : {3'b000, rom_addr};
          o_flash_dq_out <= rom_udata ? udata_reg : {8'h00, rom_data};
          o_flash_dq_oe  <= 1'b1;
          o_flash_oe_n   <= 1'b1;
          o_flash_ce_n   <= 1'b0;
          if (cnt_reg == L_AS) begin
            cnt_reg      <= 3'h0;
            o_flash_we_n <= 1'b0;
            state_reg    <= S_WLOW;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        S_WLOW: begin
          if (cnt_reg == L_WP) begin
            cnt_reg      <= 3'h0;
            o_flash_we_n <= 1'b1;
            state_reg    <= S_WHOLD;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        S_WHOLD: begin
          if (cnt_reg == L_DH) begin
            cnt_reg       <= 3'h0;
            o_flash_ce_n  <= 1'b1;
            o_flash_dq_oe <= 1'b0;
            state_reg     <= S_WGAP;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        S_WGAP: begin
          if (cnt_reg != L_WPH) begin
            cnt_reg <= cnt_reg + 3'h1;
          end else begin
            cnt_reg <= 3'h0;
            if (!rom_last) begin
              step_reg  <= step_reg + 3'h1;
              state_reg <= S_FETCH;
            end else if (op_reg == `FPC_OP_PROGRAM || is_erase) begin
              have_prev_reg <= 1'b0;
              tmo_reg       <= 28'h000_0000;
              state_reg     <= S_PGAP;
            end else begin
              if (op_reg == `FPC_OP_ID_ENTRY) begin
                o_id_mode <= 1'b1;
              end
              if (op_reg == `FPC_OP_ID_EXIT || op_reg == `FPC_OP_ID_EXIT2) begin
                o_id_mode <= 1'b0;
              end
              if (op_reg == `FPC_OP_LOCKOUT) begin
                o_lockout_active <= 1'b1;
              end
              o_done      <= 1'b1;
              o_cmd_ready <= 1'b1;
              state_reg   <= S_IDLE;
            end
          end
        end
        S_PGAP: begin
          // Strobes high between polls; the address of the last write stays put
          o_flash_ce_n <= 1'b1;
          o_flash_oe_n <= 1'b1;
          tmo_reg      <= tmo_reg + 28'h000_0001;
          if (cnt_reg == L_POLL_HIGH) begin
            cnt_reg      <= 3'h0;
            o_flash_ce_n <= 1'b0;
            o_flash_oe_n <= 1'b0;
            state_reg    <= S_PRD;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        S_PRD: begin
          tmo_reg <= tmo_reg + 28'h000_0001;
          if (cnt_reg != L_ACC) begin
            cnt_reg <= cnt_reg + 3'h1;
          end else begin
            cnt_reg       <= 3'h0;
            o_flash_ce_n  <= 1'b1;
            o_flash_oe_n  <= 1'b1;
            prev_tog_reg  <= tog_now;
            have_prev_reg <= 1'b1;
            if (have_prev_reg && tog_now == prev_tog_reg) begin
              o_rdata     <= i_flash_dq_in;
              o_done      <= 1'b1;
              o_cmd_ready <= 1'b1;
              state_reg   <= S_IDLE;
            end else if (tmo_reg >= tmo_limit) begin
              o_error     <= 1'b1;
              o_done      <= 1'b1;
              o_cmd_ready <= 1'b1;
              state_reg   <= S_IDLE;
            end else begin
              state_reg <= S_PGAP;
            end
          end
        end
        S_RD: begin
          if (cnt_reg == L_ACC) begin
            cnt_reg      <= 3'h0;
            o_rdata      <= i_flash_dq_in;
            o_flash_ce_n <= 1'b1;
            o_flash_oe_n <= 1'b1;
            state_reg    <= S_RGAP;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        S_RGAP: begin
          o_done      <= 1'b1;
          o_cmd_ready <= 1'b1;
          state_reg   <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule // fpc_flash_host

`default_nettype wire

// ---- verification/fpc_flash_model.sv ----
// Behavioural model of the parallel flash device seen by the host
`timescale 1ns/100ps
`default_nettype none
module fpc_flash_model #(
  parameter [15:0]  P_MAKER   = 16'h00a5, // Arbitrary maker code
  parameter [15:0]  P_PART    = 16'h005a, // Arbitrary part code
  parameter integer P_PROG_NS = 2000,
  parameter integer P_ERS_NS  = 4000
) (
  input  wire logic [17:0] i_addr,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic [15:0] i_dq,
  output logic      [15:0] o_dq
);
  logic [15:0] mem [logic [17:0]];
  logic [22:0] hist [0:2];
  logic [17:0] wa      = 18'h0_0000;
  logic [15:0] rdq     = 16'h0000;
  logic [15:0] last    = 16'h0000;
  logic        id_mode = 1'b0;
  logic        lock    = 1'b0;
  logic        arm     = 1'b0;
  logic        tog     = 1'b0;
  logic        busy    = 1'b0;
  logic        unl;
  logic        ers;
  integer      busy_ns = 0;
  integer      j;
  wire         wr_n    = i_we_n | i_ce_n;
  wire         rd_n    = i_oe_n | i_ce_n;

  // Released bus shows the inverse of the last word
  assign o_dq = rd_n ? ~last : rdq;

  initial for (j = 0; j < 3; j = j + 1) hist[j] = 23'h0;

  initial forever begin
    @(posedge busy);
    #(busy_ns) busy = 1'b0;
  end

  task automatic start(input integer ns);
    begin
      busy_ns = ns;
      busy = 1'b1;
    end
  endtask

  always @(negedge rd_n) begin
    #1;
    if (busy) begin
      tog = ~tog;
      rdq = {9'h000, tog, 6'h00};
    end else if (id_mode) begin
      rdq = i_addr[0] ? P_PART : P_MAKER;
    end else begin
      rdq = mem.exists(i_addr) ? mem[i_addr] : 16'hffff;
    end
  end

  always @(posedge rd_n) last = rdq;

  always @(negedge wr_n) wa = i_addr;

  always @(posedge wr_n) begin
    unl = hist[1] == {15'h5555, 8'haa} && hist[0] == {15'h2aaa, 8'h55};
    ers = unl && hist[2][7:0] == 8'h80;
    if (arm) begin
      arm = 1'b0;
      if (!(lock && wa <= 18'h0_1fff)) begin
        mem[wa] = i_dq;
        start(P_PROG_NS);
      end
    end else if (unl && i_dq[7:0] == 8'ha0) begin
      arm = 1'b1;
    end else if (ers && i_dq[7:0] == 8'h10 && wa[14:0] == 15'h5555) begin
      mem.delete();
      start(P_ERS_NS);
    end else if (ers && i_dq[7:0] == 8'h30) begin
      for (j = 0; j < 8192; j = j + 1) mem.delete({wa[17:13], j[12:0]});
      start(P_ERS_NS);
    end else if (ers && i_dq[7:0] == 8'h40) begin
      lock = 1'b1;
    end else if (unl && i_dq[7:0] == 8'h90) begin
      id_mode = 1'b1;
    end else if (i_dq[7:0] == 8'hf0) begin
      id_mode = 1'b0;
    end
    hist[2] = hist[1];
    hist[1] = hist[0];
    hist[0] = {wa[14:0], i_dq[7:0]};
  end
endmodule // fpc_flash_model
`default_nettype wire

// ---- verification/fpc_flash_host_sva.sv ----
// Concurrent checks on the flash host controller ports
`timescale 1ns/100ps
`default_nettype none
`include "fpc_flash_regs.vh"
module fpc_flash_host_sva (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_cmd_valid,
  input wire logic [2:0]  i_cmd_op,
  input wire logic [17:0] i_cmd_addr,
  input wire logic        o_cmd_ready,
  input wire logic        o_done,
  input wire logic        o_refused,
  input wire logic        o_id_mode,
  input wire logic        o_lockout_active,
  input wire logic [17:0] o_flash_addr,
  input wire logic        o_flash_ce_n,
  input wire logic        o_flash_oe_n,
  input wire logic        o_flash_we_n,
  input wire logic [15:0] o_flash_dq_out,
  input wire logic        o_flash_dq_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_wr_oe_high: assert property (!o_flash_we_n && !o_flash_ce_n |-> o_flash_oe_n)
    else $error("Output enable low during a write");
  a_no_contend: assert property (!o_flash_oe_n |-> !o_flash_dq_oe)
    else $error("Host drives data while output enable is low");
  a_we_pulse: assert property ($fell(o_flash_we_n) |-> (!o_flash_we_n)[*3] ##1 o_flash_we_n)
    else $error("Write pulse is not three cycles");
  a_wr_setup: assert property ($fell(o_flash_we_n) |-> $stable(o_flash_addr) &&
    $stable(o_flash_dq_out) && o_flash_dq_oe && !o_flash_ce_n)
    else $error("Address or data not set before write strobe");
  a_wr_hold: assert property ($rose(o_flash_we_n) |-> $stable(o_flash_addr) &&
    $stable(o_flash_dq_out) && o_flash_dq_oe && !o_flash_ce_n ##1 o_flash_ce_n && !o_flash_dq_oe)
    else $error("Address or data not held after write strobe");
  a_read_walk: assert property (i_cmd_valid && o_cmd_ready && i_cmd_op == `FPC_OP_READ |->
    ##[1:2] ($fell(o_flash_oe_n) && !o_flash_ce_n && o_flash_addr == i_cmd_addr) ##0
    (!o_flash_oe_n)[*3] ##1 o_flash_oe_n ##[1:2] o_done)
    else $error("Read cycle out of shape");
  a_refuse_take: assert property (i_cmd_valid && o_cmd_ready && o_lockout_active &&
    i_cmd_op == `FPC_OP_PROGRAM && i_cmd_addr <= `FPC_BOOT_HI |->
    ##[1:2] (o_done && o_refused && o_flash_ce_n && o_flash_we_n))
    else $error("Boot block program not refused");
  a_refused_done: assert property (o_refused |-> o_done && o_flash_we_n)
    else $error("Refusal without completion");
  a_id_change: assert property ($changed(o_id_mode) |-> o_done)
    else $error("Identification flag changed outside completion");
  a_lock_rise: assert property ($rose(o_lockout_active) |-> o_done)
    else $error("Lockout flag rose outside completion");
  a_poll_addr: assert property ($fell(o_flash_oe_n) && !$past(o_cmd_ready) |->
    $stable(o_flash_addr))
    else $error("Polling read address moved");
endmodule // fpc_flash_host_sva
bind fpc_flash_host fpc_flash_host_sva fpc_flash_host_sva_inst (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
  .i_cmd_addr(i_cmd_addr), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
  .o_refused(o_refused), .o_id_mode(o_id_mode), .o_lockout_active(o_lockout_active),
  .o_flash_addr(o_flash_addr), .o_flash_ce_n(o_flash_ce_n), .o_flash_oe_n(o_flash_oe_n),
  .o_flash_we_n(o_flash_we_n), .o_flash_dq_out(o_flash_dq_out), .o_flash_dq_oe(o_flash_dq_oe));
`default_nettype wire

// ---- verification/fpc_flash_host_test.sv ----
// Self-checking bench for the flash host controller with a device model
`timescale 1ns/100ps
`default_nettype none
module fpc_flash_host_test;
  localparam [15:0] MAKER = 16'h00a5; // Arbitrary maker code
  localparam [15:0] PART  = 16'h005a; // Arbitrary part code
  logic        i_clk       = 1'b0;
  logic        i_reset_n   = 1'b0;
  logic        i_cmd_valid = 1'b0;
  logic [2:0]  i_cmd_op    = 3'h0;
  logic [17:0] i_cmd_addr  = 18'h0_0000;
  logic [15:0] i_cmd_wdata = 16'h0000;
  wire         o_cmd_ready, o_done, o_error, o_refused, o_id_mode, o_lockout_active;
  wire         o_flash_ce_n, o_flash_oe_n, o_flash_we_n, o_flash_dq_oe;
  wire  [15:0] o_rdata, o_flash_dq_out, mdl_dq;
  wire  [17:0] o_flash_addr;
  wire  [15:0] dq_bus = o_flash_dq_oe ? o_flash_dq_out : mdl_dq;
  integer      errors = 0, checks = 0, cycles = 0, i, j;
  logic [15:0] shadow [logic [17:0]];
  logic [17:0] a, b;
  logic [15:0] d;
  logic        refused_seen;

  fpc_flash_host #(.P_ERASE_TMO_CYC(28'd200)) fpc_flash_host_inst (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
    .i_cmd_addr(i_cmd_addr), .i_cmd_wdata(i_cmd_wdata), .o_cmd_ready(o_cmd_ready),
    .o_done(o_done), .o_error(o_error), .o_refused(o_refused), .o_rdata(o_rdata),
    .o_id_mode(o_id_mode), .o_lockout_active(o_lockout_active), .o_flash_addr(o_flash_addr),
    .o_flash_ce_n(o_flash_ce_n), .o_flash_oe_n(o_flash_oe_n), .o_flash_we_n(o_flash_we_n),
    .o_flash_dq_out(o_flash_dq_out), .o_flash_dq_oe(o_flash_dq_oe), .i_flash_dq_in(dq_bus));
  fpc_flash_model #(.P_MAKER(MAKER), .P_PART(PART)) fpc_flash_model_inst (
    .i_addr(o_flash_addr), .i_ce_n(o_flash_ce_n), .i_oe_n(o_flash_oe_n),
    .i_we_n(o_flash_we_n), .i_dq(dq_bus), .o_dq(mdl_dq));

  initial forever #20 i_clk = ~i_clk;

  task automatic close_out;
    begin
      if (errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask

  always @(posedge i_clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      errors = errors + 1;
      close_out;
    end
  end

  task automatic check(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  function automatic [15:0] expv(input [17:0] ad);
    expv = shadow.exists(ad) ? shadow[ad] : 16'hffff;
  endfunction

  task automatic run(input [2:0] op, input [17:0] ad, input [15:0] wd);
    begin
      i_cmd_op <= op;
      i_cmd_addr <= ad;
      i_cmd_wdata <= wd;
      i_cmd_valid <= 1'b1;
      @(posedge i_clk);
      while (!o_cmd_ready) @(posedge i_clk);
      i_cmd_valid <= 1'b0;
      while (!o_done) @(posedge i_clk);
      refused_seen = o_refused;
    end
  endtask

  initial begin
    void'($urandom(25));
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    check({12'h0, o_flash_ce_n, o_flash_oe_n, o_flash_we_n, o_flash_dq_oe}, 16'h000e);
    for (i = 0; i < 4; i = i + 1) begin
      a = 18'h0_2000 + 18'($urandom % 32'h3_e000);
      d = 16'($urandom);
      run(3'h1, a, d);
      shadow[a] = d;
      check({15'h0, o_error}, 16'h0000);
      run(3'h0, a, 16'h0000);
      check(o_rdata, expv(a));
    end
    b = a ^ 18'h2_0000;
    d = 16'($urandom);
    run(3'h1, b, d);
    shadow[b] = d;
    run(3'h3, {a[17:13], ~a[12:0]}, 16'h0000);
    for (j = 0; j < 8192; j = j + 1) shadow.delete({a[17:13], j[12:0]});
    run(3'h0, a, 16'h0000);
    check(o_rdata, expv(a));
    run(3'h0, b, 16'h0000);
    check(o_rdata, expv(b));
    run(3'h2, 18'h0_0000, 16'h0000);
    shadow.delete();
    run(3'h0, b, 16'h0000);
    check(o_rdata, expv(b));
    run(3'h1, b, d);
    shadow[b] = d;
    for (i = 5; i < 7; i = i + 1) begin
      run(3'h4, 18'h0_0000, 16'h0000);
      check({15'h0, o_id_mode}, 16'h0001);
      run(3'h0, 18'h0_0000, 16'h0000);
      check(o_rdata, MAKER);
      run(3'h0, 18'h0_0001, 16'h0000);
      check(o_rdata, PART);
      run(3'(i), 18'h0_0000, 16'h0000);
      run(3'h0, b, 16'h0000);
      check(o_rdata, expv(b));
    end
    run(3'h7, 18'h0_0000, 16'h0000);
    check({15'h0, o_lockout_active}, 16'h0001);
    for (i = 0; i < 4; i = i + 1) begin
      a = (i == 0) ? 18'h0_1fff : (i == 1) ? 18'h0_2000 : 18'($urandom % 32'h2000);
      d = 16'($urandom);
      run(3'h1, a, d);
      if (i == 1) shadow[a] = d;
      check({15'h0, refused_seen}, {15'h0, i != 1});
      run(3'h0, a, 16'h0000);
      check(o_rdata, expv(a));
    end
    run(3'h4, 18'h0_0000, 16'h0000);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    check({15'h0, o_id_mode}, 16'h0000);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    run(3'h6, 18'h0_0000, 16'h0000);
    run(3'h0, b, 16'h0000);
    check(o_rdata, expv(b));
    close_out;
  end
endmodule // fpc_flash_host_test
`default_nettype wire
